// file: page_window_consts.svh
// Constants of the page window access unit: register offsets, fields,
// reset values and window addresses.
// Assumes inclusion by bare name from files that need them.
`ifndef PAGE_WINDOW_CONSTS_SVH
`define PAGE_WINDOW_CONSTS_SVH

// Register byte offsets on the Avalon slave
`define PW_REG_ACC1     6'h00
`define PW_REG_ACC2     6'h04
`define PW_REG_ACC3     6'h08
`define PW_REG_CMD      6'h0c
`define PW_REG_STAT     6'h10
`define PW_REG_IRQ_STAT 6'h14
`define PW_REG_IRQ_MASK 6'h18
`define PW_REG_CFG      6'h1c

// Command, status and configuration fields
`define PW_CMD_WRITE_BIT   0
`define PW_CMD_READ_BIT    1
`define PW_STAT_BUSY_BIT   4
`define PW_CFG_SIZE2K_BIT  0
`define PW_CFG_PAGES_BIT   1
`define PW_CFG_RESET       2'h2

// Interrupt event bits
`define PW_EV_DONE_BIT  0
`define PW_EV_ABORT_BIT 1
`define PW_EV_WIDTH     2

// Shared window addresses
`define PW_WIN_BASE     16'hf400
`define PW_WIN_END_1K   16'hf7ff
`define PW_WIN_END_2K   16'hfbff
`define PW_SEL_ADDR     16'hfeff
`define PW_PAGE_1K      12'h400
`define PW_PAGE_2K      12'h800

// Transfer size codes
`define PW_SIZE_BYTE    8'h00
`define PW_SIZE_WORD    8'h01
`define PW_SIZE_DWORD   8'h02

`endif

// file: page_window_pkg.sv
// Types shared by the page window access unit.
// Assumes nothing beyond a SystemVerilog compiler.
package page_window_pkg;
    typedef enum logic [3:0] {
        st_idle, st_check, st_req, st_sel, st_sel_rel,
        st_present, st_xfer, st_xfer_rel, st_finish
    } xfer_state_t;
    typedef logic [31:0] accu_t;
endpackage : page_window_pkg

// file: page_irq_if.sv
// Interface between the register block and the interrupt status logic.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface page_irq_if;
    logic [1:0] events;
    logic       status_rd;
    logic       mask_wr;
    logic [1:0] mask_wdata;
    logic [1:0] status;
    logic [1:0] mask;
    logic       irq;
    modport ctl (output events, output status_rd, output mask_wr, output mask_wdata,
                 input status, input mask, input irq);
    modport irq_side (input events, input status_rd, input mask_wr, input mask_wdata,
                      output status, output mask, output irq);
endinterface : page_irq_if
`default_nettype wire

// file: pin_sync.sv
// Two flip-flop synchroniser for pin inputs of any width.
// Assumes inputs are levels that stay stable for several clocks.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_pin;
            o_sync <= meta;
        end
    end
endmodule : pin_sync
`default_nettype wire

// file: page_irq.sv
// Sticky event status, mask and level interrupt of the page window unit.
// Assumes a status read lasts one cycle of status_rd.
`timescale 1ns/1ps
`default_nettype none
module page_irq (
    input  wire logic   i_clk,
    input  wire logic   i_nrst,
    page_irq_if.irq_side bus
);
    // Set wins over the read clear so an event in the status_rd cycle is not lost
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            bus.status <= 2'h0;
        end else begin
            bus.status <= (bus.status_rd ? 2'h0 : bus.status) | bus.events;
        end
    end

    // Mask written by software, reset masks everything
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            bus.mask <= 2'h0;
        end else if (bus.mask_wr) begin
            bus.mask <= bus.mask_wdata;
        end
    end

    assign bus.irq = |(bus.status & bus.mask);
endmodule : page_irq
`default_nettype wire

// file: page_window_access_unit.sv
// Page window access unit: byte, word and dword page transfers
// through the shared address window, driven from registers.
// Assumes an Avalon-MM master on i_clk and a four-phase strobe/ack window bus
// whose ack, grant and page-present pins come from outside the clock domain.
//
// Operation
// - 1K pages map at F400H to F7FFH
// - 2K pages map at F400H to FBFFH
// - Select register picks page; modules answer selected
// - Never read the select location FEFF
// - Write sends 1/2/4 right-justified bytes of acc1
// - Write offset acc2 low, page acc3 LL
// - Read offset acc2 low, page acc3 LL
// - Size code 0/1/2 byte/word/dword, others illegal
// - Pages 0-255, offsets 0-2047, nonexistent offset rejected
// - Select plus data transfer is indivisible
// - Abort on bad size, offset, page, none
// - Abort keeps accumulators, clears all condition codes
// - Write success: advance acc2 low, set flag
// - Read success: data right-justified, upper bits zero
// - Read success: advance acc2 low, flag reset
`include "page_window_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module page_window_access_unit (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Avalon-MM slave
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic             o_irq,
    // Shared window bus
    output logic             o_bus_req,
    input  wire logic        i_bus_grant,
    output logic      [15:0] o_win_addr,
    output logic      [7:0]  o_win_wdata,
    output logic             o_win_wr,
    output logic             o_win_rd,
    input  wire logic [7:0]  i_win_rdata,
    input  wire logic        i_win_ack,
    input  wire logic        i_page_present
);
    page_window_pkg::accu_t      acc1;
    page_window_pkg::accu_t      acc2;
    page_window_pkg::accu_t      acc3;
    page_window_pkg::accu_t      rbuf;
    page_window_pkg::xfer_state_t state;
    logic [3:0]  cc;
    logic [1:0]  cfg;
    logic        is_read;
    logic [2:0]  nbytes;
    logic [2:0]  bidx;
    logic        rd_pend;
    logic        busy;
    logic        done_ok;
    logic        done_abort;
    logic        start_wr;
    logic        start_rd;
    logic        acc_wr_hit;
    logic        stall;
    logic [2:0]  sync_in;
    logic        ack_s;
    logic        grant_s;
    logic        present_s;
    logic [31:0] next_readdata;
    logic [11:0] page_bytes;
    logic [16:0] end_off;

    page_irq_if irq_bus ();

    // Byte-lane merge for software writes
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // Byte count of a size code, zero for an illegal code
    function automatic logic [2:0] size_bytes(input logic [7:0] code);
        if (code == `PW_SIZE_BYTE) begin
            return 3'h1;
        end else if (code == `PW_SIZE_WORD) begin
            return 3'h2;
        end else if (code == `PW_SIZE_DWORD) begin
            return 3'h4;
        end else begin
            return 3'h0;
        end
    endfunction : size_bytes

    // Window bus pins are from another domain
    pin_sync #(.WIDTH(3)) u_sync (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_pin  ({i_win_ack, i_bus_grant, i_page_present}),
        .o_sync (sync_in)
    );
    assign ack_s     = sync_in[2];
    assign grant_s   = sync_in[1];
    assign present_s = sync_in[0];

    page_irq u_irq (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .bus    (irq_bus)
    );

    assign busy = (state != page_window_pkg::st_idle);

    // Operand and command writes stall while busy, so software
    // cannot disturb operands or start a second transfer
    assign acc_wr_hit = i_avs_write && (i_avs_address == `PW_REG_ACC1 ||
                        i_avs_address == `PW_REG_ACC2 || i_avs_address == `PW_REG_ACC3 ||
                        i_avs_address == `PW_REG_CMD);
    assign stall = acc_wr_hit && busy;
    assign o_avs_waitrequest = stall || (i_avs_read && !rd_pend);

    assign start_wr = i_avs_write && !busy && i_avs_address == `PW_REG_CMD &&
                      i_avs_byteenable[0] && i_avs_writedata[`PW_CMD_WRITE_BIT] &&
                      !i_avs_writedata[`PW_CMD_READ_BIT];
    assign start_rd = i_avs_write && !busy && i_avs_address == `PW_REG_CMD &&
                      i_avs_byteenable[0] && i_avs_writedata[`PW_CMD_READ_BIT] &&
                      !i_avs_writedata[`PW_CMD_WRITE_BIT];

    // Read takes two cycles: load readdata, then release
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= i_avs_read && !rd_pend;
        end
    end

    // Readback mux
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (i_avs_address == `PW_REG_ACC1) begin
            next_readdata = acc1;
        end else if (i_avs_address == `PW_REG_ACC2) begin
            next_readdata = acc2;
        end else if (i_avs_address == `PW_REG_ACC3) begin
            next_readdata = acc3;
        end else if (i_avs_address == `PW_REG_STAT) begin
            next_readdata = {27'h0, busy, cc};
        end else if (i_avs_address == `PW_REG_IRQ_STAT) begin
            next_readdata = {30'h0, irq_bus.status};
        end else if (i_avs_address == `PW_REG_IRQ_MASK) begin
            next_readdata = {30'h0, irq_bus.mask};
        end else if (i_avs_address == `PW_REG_CFG) begin
            next_readdata = {30'h0, cfg};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !rd_pend) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // Interrupt side: events, read-to-clear and mask writes
    assign irq_bus.events     = {done_abort, done_ok};
    assign irq_bus.status_rd  = i_avs_read && rd_pend && i_avs_address == `PW_REG_IRQ_STAT;
    assign irq_bus.mask_wr    = i_avs_write && i_avs_address == `PW_REG_IRQ_MASK &&
                                i_avs_byteenable[0];
    assign irq_bus.mask_wdata = i_avs_writedata[1:0];
    assign o_irq              = irq_bus.irq;

    // Configuration: page size and whether any paged module is fitted
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cfg <= `PW_CFG_RESET;
        end else if (i_avs_write && i_avs_address == `PW_REG_CFG && i_avs_byteenable[0]) begin
            cfg <= i_avs_writedata[1:0];
        end
    end

    assign page_bytes = cfg[`PW_CFG_SIZE2K_BIT] ? `PW_PAGE_2K : `PW_PAGE_1K;
    // Last byte offset plus one; must fit inside the page
    assign end_off = {1'b0, acc2[15:0]} + {14'h0, size_bytes(acc3[15:8])};

    // Transfer sequencer
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state <= page_window_pkg::st_idle;
        end else begin
            case (state)
                page_window_pkg::st_idle: begin
                    if (start_wr || start_rd) begin
                        state <= page_window_pkg::st_check;
                    end
                end
                page_window_pkg::st_check: begin
                    if (nbytes == 3'h0 || !cfg[`PW_CFG_PAGES_BIT] ||
                        end_off > {5'h0, page_bytes}) begin
                        state <= page_window_pkg::st_finish;
                    end else begin
                        state <= page_window_pkg::st_req;
                    end
                end
                page_window_pkg::st_req: begin
                    if (grant_s) begin
                        state <= page_window_pkg::st_sel;
                    end
                end
                page_window_pkg::st_sel: begin
                    if (ack_s) begin
                        state <= page_window_pkg::st_sel_rel;
                    end
                end
                page_window_pkg::st_sel_rel: begin
                    if (!ack_s) begin
                        state <= page_window_pkg::st_present;
                    end
                end
                page_window_pkg::st_present: begin
                    if (present_s) begin
                        state <= page_window_pkg::st_xfer;
                    end else begin
                        state <= page_window_pkg::st_finish;
                    end
                end
                page_window_pkg::st_xfer: begin
                    if (ack_s) begin
                        state <= page_window_pkg::st_xfer_rel;
                    end
                end
                page_window_pkg::st_xfer_rel: begin
                    if (!ack_s) begin
                        if (bidx == nbytes - 3'h1) begin
                            state <= page_window_pkg::st_finish;
                        end else begin
                            state <= page_window_pkg::st_xfer;
                        end
                    end
                end
                default: begin
                    state <= page_window_pkg::st_idle;
                end
            endcase
        end
    end

    // Operation latch and byte index
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            is_read <= 1'b0;
            nbytes  <= 3'h0;
            bidx    <= 3'h0;
        end else if (state == page_window_pkg::st_idle) begin
            is_read <= start_rd;
            nbytes  <= size_bytes(acc3[15:8]);
            bidx    <= 3'h0;
        end else if (state == page_window_pkg::st_xfer_rel && !ack_s) begin
            bidx <= bidx + 3'h1;
        end
    end

    // Outcome pulses, one cycle in st_finish
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            done_ok    <= 1'b0;
            done_abort <= 1'b0;
        end else begin
            done_ok    <= 1'b0;
            done_abort <= 1'b0;
            if (state == page_window_pkg::st_check && (nbytes == 3'h0 ||
                !cfg[`PW_CFG_PAGES_BIT] || end_off > {5'h0, page_bytes})) begin
                done_abort <= 1'b1;
            end else if (state == page_window_pkg::st_present && !present_s) begin
                done_abort <= 1'b1;
            end else if (state == page_window_pkg::st_xfer_rel && !ack_s &&
                         bidx == nbytes - 3'h1) begin
                done_ok <= 1'b1;
            end
        end
    end

    // Shared bus held from request through the last data byte
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_bus_req <= 1'b0;
        end else begin
            o_bus_req <= state == page_window_pkg::st_req || state == page_window_pkg::st_sel ||
                         state == page_window_pkg::st_sel_rel ||
                         state == page_window_pkg::st_present ||
                         state == page_window_pkg::st_xfer ||
                         state == page_window_pkg::st_xfer_rel;
        end
    end

    // Window strobes: select location written only; data bytes
    // land in the page window, big-endian from the offset
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_win_addr  <= 16'h0000;
            o_win_wdata <= 8'h00;
            o_win_wr    <= 1'b0;
            o_win_rd    <= 1'b0;
        end else begin
            o_win_wr <= 1'b0;
            o_win_rd <= 1'b0;
            if (state == page_window_pkg::st_req && grant_s) begin
                o_win_addr  <= `PW_SEL_ADDR;
                o_win_wdata <= acc3[7:0];
                o_win_wr    <= 1'b1;
            end else if (state == page_window_pkg::st_sel && !ack_s) begin
                o_win_wr <= 1'b1;
            end else if ((state == page_window_pkg::st_present && present_s) ||
                         (state == page_window_pkg::st_xfer_rel && !ack_s &&
                          bidx != nbytes - 3'h1)) begin
                // Next byte index comes from the present bidx
                o_win_addr  <= `PW_WIN_BASE + acc2[15:0] +
                               ((state == page_window_pkg::st_present) ? 16'h0000 :
                                {13'h0, bidx + 3'h1});
                o_win_wdata <= acc1[((state == page_window_pkg::st_present) ?
                                     (nbytes - 3'h1) : (nbytes - bidx - 3'h2)) * 8 +: 8];
                o_win_wr    <= !is_read;
                o_win_rd    <= is_read;
            end else if (state == page_window_pkg::st_xfer && !ack_s) begin
                o_win_wr <= !is_read;
                o_win_rd <= is_read;
            end
        end
    end

    // Read assembly, most significant byte first, upper bits zero
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rbuf <= 32'h0000_0000;
        end else if (state == page_window_pkg::st_check) begin
            rbuf <= 32'h0000_0000;
        end else if (state == page_window_pkg::st_xfer && ack_s && is_read) begin
            rbuf <= {rbuf[23:0], i_win_rdata};
        end
    end

    // Accumulators: software loads, hardware updates only on success
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            acc1 <= 32'h0000_0000;
            acc2 <= 32'h0000_0000;
            acc3 <= 32'h0000_0000;
        end else if (done_ok) begin
            acc2[15:0] <= acc2[15:0] + {13'h0, nbytes};
            if (is_read) begin
                acc1 <= rbuf;
            end
        end else if (i_avs_write && !busy) begin
            if (i_avs_address == `PW_REG_ACC1) begin
                acc1 <= be_merge(acc1, i_avs_writedata, i_avs_byteenable);
            end else if (i_avs_address == `PW_REG_ACC2) begin
                acc2 <= be_merge(acc2, i_avs_writedata, i_avs_byteenable);
            end else if (i_avs_address == `PW_REG_ACC3) begin
                acc3 <= be_merge(acc3, i_avs_writedata, i_avs_byteenable);
            end
        end
    end

    // Condition codes: bit 0 is the logic_result_flag; software may
    // load the rest and every transfer clears them
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cc <= 4'h0;
        end else if (done_abort) begin
            cc <= 4'h0;
        end else if (done_ok) begin
            cc <= {3'h0, !is_read};
        end else if (i_avs_write && !busy && i_avs_address == `PW_REG_STAT &&
                     i_avs_byteenable[0]) begin
            cc <= i_avs_writedata[3:0];
        end
    end
endmodule : page_window_access_unit
`default_nettype wire

// file: page_window_partner.sv
// Paged memory model: select register, grant, four-phase ack.
// Assumes strobes held until ack; answers at once or late.
`timescale 1ns/1ps
`default_nettype none
module page_window_partner #(
    parameter logic [7:0] ABSENT = 8'h33
) (
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    input  wire logic        i_req,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic             o_grant,
    output logic             o_ack,
    output logic             o_present,
    output logic      [7:0]  o_rdata
);
    logic [7:0]  mem [logic [23:0]];
    logic [7:0]  sel = 8'h00;
    logic [2:0]  dly = 3'h0;
    wire  [23:0] key = {sel, i_addr};
    initial {o_grant, o_ack, o_present, o_rdata} = 11'h000;
    // Only the selected page answers; idle data toggles
    always @(posedge i_clk) begin
        o_grant <= i_req;
        o_present <= (sel != ABSENT);
        if (!(i_wr || i_rd)) begin
            o_ack <= 1'b0;
            dly <= 3'h0;
            o_rdata <= ~o_rdata;
        end else if (!o_ack && dly >= (i_slow ? 3'h4 : 3'h0)) begin
            o_ack <= 1'b1;
            if (i_wr && i_addr == `PW_SEL_ADDR) sel <= i_wdata;
            else if (i_wr) mem[key] = i_wdata;
            else o_rdata <= mem.exists(key) ? mem[key] : 8'h00;
        end else if (!o_ack) dly <= dly + 3'h1;
    end
endmodule : page_window_partner
`default_nettype wire

// file: page_window_access_unit_props.sv
// Port checks: window strobes, bus ownership, Avalon wait.
// Assumes the bind below and the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "page_window_consts.svh"
module page_window_access_unit_props (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_avs_read,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_bus_req,
    input wire logic [15:0] o_win_addr,
    input wire logic [7:0]  o_win_wdata,
    input wire logic        o_win_wr,
    input wire logic        o_win_rd,
    input wire logic        i_win_ack
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Held strobe, quiet while grant syncs
    sequence s_held; (o_win_wr || o_win_rd) ##1 (o_win_wr || o_win_rd); endsequence
    sequence s_quiet; !(o_win_wr || o_win_rd) [*2]; endsequence
    property p_no_sel_read; o_win_rd |-> o_win_addr != `PW_SEL_ADDR; endproperty
    a_no_sel_read: assert property (p_no_sel_read) else $error("sel read");
    property p_in_window; (o_win_wr || o_win_rd) && o_win_addr != `PW_SEL_ADDR
        |-> o_win_addr inside {[`PW_WIN_BASE:`PW_WIN_END_2K]}; endproperty
    a_in_window: assert property (p_in_window) else $error("off window");
    property p_one_dir; !(o_win_wr && o_win_rd); endproperty
    a_one_dir: assert property (p_one_dir) else $error("wr and rd");
    property p_bus_owned; (o_win_wr || o_win_rd) |-> o_bus_req; endproperty
    a_bus_owned: assert property (p_bus_owned) else $error("no bus req");
    property p_stable; s_held |-> $stable(o_win_addr) && $stable(o_win_wdata); endproperty
    a_stable: assert property (p_stable) else $error("addr moved");
    property p_drop; $fell(o_win_wr || o_win_rd)
        |-> $past(i_win_ack, 2) || $past(i_win_ack, 3) || $past(i_win_ack, 4); endproperty
    a_drop: assert property (p_drop) else $error("no ack");
    property p_read_wait; $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait");
    property p_sync_lag; $rose(o_bus_req) |-> s_quiet; endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("early strobe");
    property p_sel_first; $rose(o_bus_req)
        |-> ##[1:60] (o_win_wr && o_win_addr == `PW_SEL_ADDR); endproperty
    a_sel_first: assert property (p_sel_first) else $error("no select");
endmodule : page_window_access_unit_props
bind page_window_access_unit page_window_access_unit_props i_props (.i_clk, .i_nrst,
    .i_avs_read, .o_avs_waitrequest, .o_bus_req, .o_win_addr, .o_win_wdata, .o_win_wr,
    .o_win_rd, .i_win_ack);
`default_nettype wire

// file: test_page_window_access_unit.sv
// Bench: random page writes, each read back.
// Assumes the partner model and the checker.
`timescale 1ns/1ps
`default_nettype none
`include "page_window_consts.svh"
module test_page_window_access_unit;
    logic        i_clk, i_nrst, rd, wr, slow, wreq, irq, req, grant, wwr, wrd, ack, pres;
    logic [5:0]  adr;
    logic [31:0] wdat, rdat;
    logic [15:0] waddr;
    logic [7:0]  wdata, rdata;
    logic [7:0]  mir [logic [23:0]];
    integer      seed = 32'hd5c6;
    int          num_errors = 0, samples_checked = 0, cyc = 0;
    page_window_access_unit i_dut (.i_clk, .i_nrst, .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq), .o_bus_req(req),
        .i_bus_grant(grant), .o_win_addr(waddr), .o_win_wdata(wdata), .o_win_wr(wwr),
        .o_win_rd(wrd), .i_win_rdata(rdata), .i_win_ack(ack), .i_page_present(pres));
    page_window_partner i_far (.i_clk, .i_slow(slow), .i_req(req), .i_wr(wwr), .i_rd(wrd),
        .i_addr(waddr), .i_wdata(wdata), .o_grant(grant), .o_ack(ack), .o_present(pres),
        .o_rdata(rdata));
    // Clock, hang limit
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
    end
    // Comparison and verdict
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp);
        chk32(32'(got), 32'(exp));
    endtask : chk1
    task automatic results;
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    // Avalon master
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n = 0;
        @(posedge i_clk);
        {rd, wr, adr, wdat} <= {!w, w, a, d};
        do @(posedge i_clk); while (wreq !== 1'b0 && n++ < 300);
        if (n >= 300) num_errors++;
        q = rdat;
        {rd, wr} <= 2'h0;
    endtask : bus
    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk32(q, e);
    endtask : rchk
    function automatic logic [23:0] key(input logic [7:0] pg, input logic [15:0] off, int i);
        key = {pg, `PW_WIN_BASE + off + 16'(i)};
    endfunction : key
    // One transfer and its expected results
    task automatic op(input logic w, input logic [7:0] pg, input logic [7:0] sz,
                      input logic [15:0] off, input logic [31:0] d, input logic [1:0] cfg,
                      input logic [1:0] mask);
        logic [31:0] a2, a3, e1, q;
        int          n, t;
        logic        ok;
        n = 1 << sz[1:0];
        ok = sz < 3 && int'(off) + n <= (cfg[0] ? 2048 : 1024) && cfg[1] && pg != 8'h33;
        a2 = {16'($random(seed)), off};
        a3 = {16'($random(seed)), sz, pg};
        e1 = (ok && !w) ? 32'h0 : d;
        for (int i = 0; i < n && ok; i++)
            if (w) mir[key(pg, off, i)] = d[8*(n-1-i) +: 8];
            else e1 = {e1[23:0], mir.exists(key(pg, off, i)) ? mir[key(pg, off, i)] : 8'h00};
        wreg(`PW_REG_CFG, {30'h0, cfg});
        wreg(`PW_REG_IRQ_MASK, {30'h0, mask});
        wreg(`PW_REG_STAT, 32'hf);
        wreg(`PW_REG_ACC1, d);
        wreg(`PW_REG_ACC2, a2);
        wreg(`PW_REG_ACC3, a3);
        wreg(`PW_REG_CMD, w ? 32'h1 : 32'h2);
        t = 0;
        do bus(1'b0, `PW_REG_STAT, 32'h0, q); while (q[4] !== 1'b0 && t++ < 200);
        rchk(`PW_REG_ACC1, e1);
        rchk(`PW_REG_ACC2, ok ? {a2[31:16], off + 16'(n)} : a2);
        rchk(`PW_REG_ACC3, a3);
        rchk(`PW_REG_STAT, {31'h0, ok & w});
        @(negedge i_clk);
        chk1(irq, |({!ok, ok} & mask));
        rchk(`PW_REG_IRQ_STAT, {30'h0, !ok, ok});
        @(negedge i_clk);
        chk1(irq, 1'b0);
    endtask : op
    // Reset, defaults, then random write and read-back pairs
    initial begin
        logic [15:0] off;
        logic [7:0]  pg, sz;
        i_nrst = 1'b0;
        {rd, wr, slow, adr, wdat} = '0;
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        rchk(`PW_REG_CFG, {30'h0, `PW_CFG_RESET});
        rchk(`PW_REG_IRQ_MASK, 32'h0);
        wreg(6'h20, 32'($random(seed)));
        rchk(6'h20, 32'h0);
        for (int k = 0; k < 40; k++) begin
            pg = k[0] ? 8'h07 : (($random(seed) & 3) == 0 ? 8'h33 : 8'($random(seed)));
            sz = k < 4 ? 8'(k) : 8'($random(seed) & 3);
            off = k[1] ? (k[2] ? 16'h7fc : 16'h3fc) + 16'($random(seed) & 7)
                       : 16'($random(seed) & 16'h7ff);
            slow <= 1'($random(seed));
            op(1'b1, pg, sz, off, $random(seed), k == 9 ? 2'h1 : {1'b1, k > 19}, 2'($random(seed)));
            op(1'b0, pg, sz, off, $random(seed), k == 9 ? 2'h1 : {1'b1, k > 19}, 2'($random(seed)));
        end
        results();
    end
endmodule : test_page_window_access_unit
`default_nettype wire
